// ---- rtl/bps_pkg.sv ----
//------------------------------------------------------------------------
// Buck PWM sequencer constants
//------------------------------------------------------------------------
// Notes on behaviour
// - Switching clock comes from internal oscillator, or from sync input when clocked.
// - High-side turns on each clock edge; off at duty, maximum duty or overcurrent.
// - Duty end compares error level against a ramp restarted every switching cycle.
// - Non-synchronous variant: bootstrap refresh switch on in off-time every fourth cycle.
// - Overcurrent turns high-side off at once until the next cycle begins.
// - Synchronous variant: low-side drive waits 25 ns dead time after high-side off.
// - Synchronous variant keeps low-side on for the rest of every off-time.
// - High-side waits for low-side drive low; low-side waits for high-side gate low.
// - Enable is active high: high turns converter on, low turns it off.
// - Enable rising starts the soft-start ramp of the internal reference.
// - Enable low turns high-side off and forces the good flag low.
// - Lockout holds converter off until supply reaches 4.5 V, off below 4.3 V.
// - Soft-start raises the reference in 64 discrete steps.
// - Turn-off by enable or supply steps the reference down to zero gradually.
// - Soft-start and soft-stop each last 4096 internal oscillator cycles.
// - Lost sync clock hands the switching rate back to the internal oscillator.
// - Current limit folds switching frequency back to one quarter.
// - Reset flag released after output good, soft-start done and 200 ms timeout; the code releases it on output good alone in the synchronous variant.
package bps_pkg;

    // Clock and timing.
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned DEAD_TIME_NS = 25;
    localparam int unsigned DEAD_CYC = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SENSE_LAG_CYC = 4; // Edges through the pin synchroniser.
    localparam int unsigned GOOD_TIMEOUT_MS = 200;
    localparam int unsigned GOOD_TIMEOUT_CYC = GOOD_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned SOFT_TOTAL_OSC = 4096;
    localparam int unsigned SOFT_STEPS = 64;
    localparam int unsigned STEP_HOLD_OSC = SOFT_TOTAL_OSC / SOFT_STEPS;
    localparam int unsigned FOLD_DIV = 4;
    localparam int unsigned REFRESH_EVERY = 4;
    localparam int unsigned SYNC_LOSS_PERIODS = 2;

    // Register map, byte addresses.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DUTY = 8'h04;
    localparam logic [7:0] ADDR_PERIOD = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;

    // Field positions and reset values.
    localparam int unsigned CTRL_SYNC_VARIANT_BIT = 0;
    localparam logic [7:0] DUTY_RESET = 8'h80;
    localparam logic [7:0] DUTY_MAX = 8'he6;
    localparam logic [15:0] PERIOD_RESET = 16'h0064;
    localparam int unsigned STAT_STATE_LSB = 0;
    localparam int unsigned STAT_STEP_LSB = 8;
    localparam int unsigned STAT_FLAGS_LSB = 16;

    // Sequencer states, Gray coded along off, up, run, down.
    typedef enum logic [1:0] {
        BPS_OFF = 2'b00,
        BPS_RAMP_UP = 2'b01,
        BPS_RUN = 2'b11,
        BPS_RAMP_DOWN = 2'b10
    } bps_state_t;

    // Sensed pins and comparator levels.
    typedef struct packed {
        logic sync_clock;
        logic enable;
        logic supply_above_rise;
        logic supply_above_fall;
        logic overcurrent;
        logic output_above;
        logic low_side_fallen;
        logic high_gate_fallen;
    } bps_sense_t;

    // Gate drive outputs.
    typedef struct packed {
        logic high_side;
        logic low_side_gate_drive;
        logic bootstrap_refresh_switch;
    } bps_gate_t;

endpackage

// ---- rtl/bps_top.sv ----
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ns
module bps_top
#(
    parameter int unsigned GOOD_TIMEOUT = bps_pkg::GOOD_TIMEOUT_CYC
)
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins and comparators, asynchronous to pclk.
    input wire bps_pkg::bps_sense_t sense,
    // Gate drives and reference.
    output bps_pkg::bps_gate_t gates,
    output logic [6:0] soft_reference_level,
    // Open-drain good flag, enable low while pulling low.
    output logic output_good_flag_out,
    output logic output_good_flag_oe_n
);
    import bps_pkg::*;

    //--------------------------------------------------------------------
    // Elaboration check
    //--------------------------------------------------------------------
    if (GOOD_TIMEOUT < 1 || GOOD_TIMEOUT > 32'h0fffffff)
    begin : g_bad_timeout
        $error("GOOD_TIMEOUT out of range");
    end

    // True once cnt has reached frac/256 of period.
    function automatic logic bps_frac_reached(input logic [15:0] cnt,
                                              input logic [15:0] period,
                                              input logic [7:0] frac);
        logic [23:0] lhs;
        logic [23:0] rhs;
        lhs = {cnt, 8'h00};
        rhs = {16'h0000, frac} * {8'h00, period};
        return lhs >= rhs;
    endfunction

    //--------------------------------------------------------------------
    // Input synchronisers
    //--------------------------------------------------------------------
    bps_sense_t s1;
    bps_sense_t s2;
    bps_sense_t s3;
    bps_sense_t sn;

    // Three stages; a bit changes once stages two and three agree.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            sn <= '0;
        end
        else
        begin
            s1 <= sense;
            s2 <= s1;
            s3 <= s2;
            sn <= (s2 & s3) | (sn & (s2 | s3));
        end
    end

    //--------------------------------------------------------------------
    // Registers
    //--------------------------------------------------------------------
    logic sync_variant;
    logic [7:0] duty_cmd;
    logic [15:0] osc_period;
    logic [31:0] status_word;
    logic apb_wr;
    logic addr_ok;

    assign apb_wr = psel && penable && pwrite;
    assign addr_ok = paddr == ADDR_CTRL || paddr == ADDR_DUTY
                     || paddr == ADDR_PERIOD || paddr == ADDR_STATUS;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    // Software writes take effect at the access edge.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_variant <= 1'b0;
            duty_cmd <= DUTY_RESET;
            osc_period <= PERIOD_RESET;
        end
        else if (apb_wr)
        begin
            if (paddr == ADDR_CTRL)
                sync_variant <= pwdata[CTRL_SYNC_VARIANT_BIT];
            if (paddr == ADDR_DUTY)
                duty_cmd <= pwdata[7:0];
            if (paddr == ADDR_PERIOD && pwdata[15:0] >= 16'h0004)
                osc_period <= pwdata[15:0];
        end
    end

    // Read data registered in the setup cycle, valid during access.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= '0;
        else if (psel && !penable && !pwrite)
        begin
            case (paddr)
                ADDR_CTRL: prdata <= {31'h0, sync_variant};
                ADDR_DUTY: prdata <= {24'h0, duty_cmd};
                ADDR_PERIOD: prdata <= {16'h0, osc_period};
                ADDR_STATUS: prdata <= status_word;
                default: prdata <= '0;
            endcase
        end
    end

    //--------------------------------------------------------------------
    // Oscillator, sync and foldback
    //--------------------------------------------------------------------
    logic [15:0] osc_cnt;
    logic osc_tick;
    logic sync_prev;
    logic sync_rise;
    logic sync_active;
    logic [16:0] sync_gap;
    logic cycle_tick;
    logic fold;
    logic [1:0] fold_cnt;
    logic sw_start;
    logic oc_block;

    assign osc_tick = osc_cnt == osc_period - 16'h0001;
    assign sync_rise = sn.sync_clock && !sync_prev;
    assign cycle_tick = sync_active ? sync_rise : osc_tick;
    assign sw_start = cycle_tick && (!fold || fold_cnt == 2'(FOLD_DIV - 1));

    // Internal oscillator runs freely at the programmed period.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            osc_cnt <= '0;
        else if (osc_tick || osc_cnt >= osc_period)
            osc_cnt <= '0;
        else
            osc_cnt <= osc_cnt + 16'h0001;
    end

    // Sync edges take over; a long gap returns control to the oscillator.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_prev <= 1'b0;
            sync_active <= 1'b0;
            sync_gap <= '0;
        end
        else
        begin
            sync_prev <= sn.sync_clock;
            if (sync_rise)
            begin
                sync_active <= 1'b1;
                sync_gap <= '0;
            end
            else if (sync_gap >= 17'(SYNC_LOSS_PERIODS) * {1'b0, osc_period})
                sync_active <= 1'b0;
            else
                sync_gap <= sync_gap + 17'h00001;
        end
    end

    // Foldback engages on current limit and leaves after a clean cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fold <= 1'b0;
            fold_cnt <= '0;
        end
        else
        begin
            if (cycle_tick)
                fold_cnt <= fold_cnt + 2'h1;
            if (sn.overcurrent)
                fold <= 1'b1;
            else if (sw_start && !oc_block)
                fold <= 1'b0;
        end
    end

    //--------------------------------------------------------------------
    // Lockout and soft sequencer
    //--------------------------------------------------------------------
    logic lockout;
    logic enabled;
    bps_state_t state;
    logic [6:0] step;
    logic [5:0] hold_cnt;
    logic step_due;

    assign enabled = sn.enable && !lockout;
    assign step_due = osc_tick && hold_cnt == 6'(STEP_HOLD_OSC - 1);
    assign soft_reference_level = step;

    // Lockout with hysteresis between the two supply thresholds.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lockout <= 1'b1;
        else if (!sn.supply_above_fall)
            lockout <= 1'b1;
        else if (sn.supply_above_rise)
            lockout <= 1'b0;
    end

    // Reference ramps up on enable, down on turn-off, one step per hold.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= BPS_OFF;
            step <= '0;
            hold_cnt <= '0;
        end
        else
        begin
            if (osc_tick)
                hold_cnt <= hold_cnt + 6'h01;
            case (state)
                BPS_OFF:
                begin
                    step <= '0;
                    hold_cnt <= '0;
                    if (enabled)
                        state <= BPS_RAMP_UP;
                end
                BPS_RAMP_UP:
                begin
                    if (!enabled)
                        state <= BPS_RAMP_DOWN;
                    else if (step == 7'(SOFT_STEPS))
                        state <= BPS_RUN;
                    else if (step_due)
                        step <= step + 7'h01;
                end
                BPS_RUN:
                begin
                    if (!enabled)
                        state <= BPS_RAMP_DOWN;
                end
                BPS_RAMP_DOWN:
                begin
                    if (enabled)
                        state <= BPS_RAMP_UP;
                    else if (step == 7'h00)
                        state <= BPS_OFF;
                    else if (step_due)
                        step <= step - 7'h01;
                end
                default: state <= BPS_OFF;
            endcase
        end
    end

    //--------------------------------------------------------------------
    // Pulse generation and gate drives
    //--------------------------------------------------------------------
    logic switching;
    logic [15:0] ramp_cnt;
    logic hs_pend;
    logic pulse_end;
    logic [2:0] dead_cnt;
    logic [1:0] refresh_cnt;
    logic off_settled;

    assign switching = enabled && (state == BPS_RAMP_UP || state == BPS_RUN);
    assign pulse_end = bps_frac_reached(ramp_cnt, osc_period, duty_cmd)
                       || bps_frac_reached(ramp_cnt, osc_period, DUTY_MAX);
    // The count also waits out the synchroniser lag, so a stale fallen level cannot end it early.
    assign off_settled = dead_cnt == 3'(DEAD_CYC + SENSE_LAG_CYC);

    // Ramp restarts at each switching cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ramp_cnt <= '0;
        else if (sw_start)
            ramp_cnt <= '0;
        else if (ramp_cnt != 16'hffff)
            ramp_cnt <= ramp_cnt + 16'h0001;
    end

    // On-request and overcurrent block per switching cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hs_pend <= 1'b0;
            oc_block <= 1'b0;
        end
        else
        begin
            if (!switching)
                hs_pend <= 1'b0;
            else if (sw_start)
                hs_pend <= 1'b1;
            else if (pulse_end || sn.overcurrent || oc_block)
                hs_pend <= 1'b0;
            if (sn.overcurrent)
                oc_block <= 1'b1;
            else if (sw_start)
                oc_block <= 1'b0;
        end
    end

    // Dead-time count runs once the high-side gate has fallen.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dead_cnt <= '0;
        else if (hs_pend || gates.high_side || !sn.high_gate_fallen)
            dead_cnt <= '0;
        else if (!off_settled)
            dead_cnt <= dead_cnt + 3'h1;
    end

    // Refresh cycle counter advances once per switching cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            refresh_cnt <= '0;
        else if (sw_start)
            refresh_cnt <= refresh_cnt + 2'h1;
    end

    // Gate drives; the low side is released before the high side turns on.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gates <= '0;
        else
        begin
            gates.high_side <= switching && hs_pend && !sn.overcurrent && !oc_block
                               && !pulse_end && !gates.low_side_gate_drive
                               && (!sync_variant || sn.low_side_fallen);
            gates.low_side_gate_drive <= switching && sync_variant && !hs_pend
                                         && off_settled;
            gates.bootstrap_refresh_switch <= switching && !sync_variant && !hs_pend
                                              && off_settled
                                              && refresh_cnt == 2'(REFRESH_EVERY - 1);
        end
    end

    //--------------------------------------------------------------------
    // Good flag and status
    //--------------------------------------------------------------------
    logic [27:0] good_cnt;
    logic good;

    // Reset style waits out the timeout; power-good style follows the output.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            good_cnt <= '0;
            good <= 1'b0;
        end
        else if (!enabled || !sn.output_above)
        begin
            good_cnt <= '0;
            good <= 1'b0;
        end
        else if (sync_variant)
            good <= 1'b1;
        else if (state != BPS_RUN)
            good_cnt <= '0;
        else if (good_cnt == 28'(GOOD_TIMEOUT - 1))
            good <= 1'b1;
        else
            good_cnt <= good_cnt + 28'h0000001;
    end

    assign output_good_flag_out = 1'b0;
    assign output_good_flag_oe_n = good;

    assign status_word = {8'h0, 2'b0, lockout, sync_active, fold, good,
                          gates.high_side, gates.low_side_gate_drive,
                          1'b0, step, 6'h0, state};
endmodule

// ---- sim/bps_top_monitor.sv ----
`timescale 1ns/1ns
//----------------------------------------
// Port checker for the sequencer
//----------------------------------------
module bps_top_monitor
#(
    parameter int unsigned GOOD_TIMEOUT = 50
)
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave side.
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Pins.
    input wire bps_pkg::bps_sense_t sense,
    input wire bps_pkg::bps_gate_t gates,
    input wire logic [6:0] soft_reference_level,
    input wire logic output_good_flag_oe_n
);
    import bps_pkg::*;

    // All checks share the bus clock and its reset.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_READY: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    AST_UNMAPPED: assert property (psel && penable && paddr > 8'h0c |-> pslverr)
        else $error("unmapped access not flagged");
    AST_NO_OVERLAP: assert property (!(gates.high_side && gates.low_side_gate_drive))
        else $error("both switches on");
    AST_DEAD_TIME: assert property ($fell(gates.high_side) |-> (!gates.low_side_gate_drive)[*3])
        else $error("low side inside dead time");
    AST_OFF_GATES: assert property ((!sense.enable)[*6] |-> gates == 3'b000)
        else $error("gates on while disabled");
    AST_LOCKOUT: assert property ((!sense.supply_above_fall)[*7] |-> gates == 3'b000)
        else $error("gates on under lockout");
    AST_OVERCURRENT: assert property (sense.overcurrent[*6] ##1 gates.high_side |=> !gates.high_side)
        else $error("high side held through overcurrent");
    AST_GOOD_LOW: assert property ((!sense.enable)[*6] |-> !output_good_flag_oe_n)
        else $error("good flag released while disabled");
    AST_REF_LIMIT: assert property (soft_reference_level <= 7'h40)
        else $error("reference above full scale");
    AST_REF_STEP: assert property ($changed(soft_reference_level) |->
        (soft_reference_level == $past(soft_reference_level) + 7'h01 ||
         soft_reference_level == $past(soft_reference_level) - 7'h01))
        else $error("reference jumped");
    AST_REF_HOLD: assert property ($changed(soft_reference_level) |=> $stable(soft_reference_level)[*8])
        else $error("reference step too short");

    // Main scenarios reached.
    COV_FULL: cover property (soft_reference_level == 7'h40);
    COV_LOW: cover property ($rose(gates.low_side_gate_drive));
    COV_REFRESH: cover property ($rose(gates.bootstrap_refresh_switch));
    COV_ERR: cover property (pslverr);
endmodule

bind bps_top bps_top_monitor #(.GOOD_TIMEOUT(GOOD_TIMEOUT)) mon_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .sense(sense), .gates(gates), .soft_reference_level(soft_reference_level),
    .output_good_flag_oe_n(output_good_flag_oe_n));

// ---- sim/bps_power_stage.sv ----
`timescale 1ns/1ns
//----------------------------------------
// Power stage model
//----------------------------------------
module bps_power_stage
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Drives from the controller.
    input wire bps_pkg::bps_gate_t gates,
    input wire logic [6:0] soft_reference_level,
    input wire logic fault,
    // Sensed levels.
    output logic overcurrent,
    output logic output_above,
    output logic low_side_fallen,
    output logic high_gate_fallen
);
    import bps_pkg::*;
    logic [1:0] high_dis;
    logic [1:0] low_dis;

    // Gates take two cycles to discharge below their thresholds.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            high_dis <= 2'b11;
            low_dis <= 2'b11;
            output_above <= 1'b0;
        end
        else
        begin
            high_dis <= {high_dis[0], !gates.high_side};
            low_dis <= {low_dis[0], !gates.low_side_gate_drive};
            output_above <= soft_reference_level == 7'h40;
        end
    end

    // Comparators report fallen only after the discharge delay.
    assign high_gate_fallen = high_dis == 2'b11 && !gates.high_side;
    assign low_side_fallen = low_dis == 2'b11 && !gates.low_side_gate_drive;
    // Switch current stays over its limit while a fault is commanded.
    assign overcurrent = fault;
endmodule

// ---- sim/buck_pwm_sequencer_test.sv ----
`timescale 1ns/1ns
//----------------------------------------
// Sequencer testbench
//----------------------------------------
module buck_pwm_sequencer_test;
    import bps_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_data;
    logic rd_err, sync_clock, sync_on, enable, rise, fall, fault, oc, oa, lsf, hgf;
    logic flag_out, flag_oe_n;
    logic [6:0] ref_lvl;
    bps_sense_t sense;
    bps_gate_t gates;
    int mismatches, total_checks, sync_cnt, n, hs, lo, bs;

    // Clock and pin assembly.
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = !pclk;
    end
    assign sense = {sync_clock, enable, rise, fall, oc, oa, lsf, hgf};
    // Sync source with a period of twenty cycles, low when stopped.
    always @(posedge pclk)
    begin
        sync_cnt <= sync_on ? (sync_cnt + 1) % 20 : 0;
        sync_clock <= sync_on && sync_cnt < 10;
    end

    bps_top #(.GOOD_TIMEOUT(50)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sense(sense), .gates(gates),
        .soft_reference_level(ref_lvl), .output_good_flag_out(flag_out),
        .output_good_flag_oe_n(flag_oe_n));
    bps_power_stage stage_u (.pclk(pclk), .presetn(presetn), .gates(gates),
        .soft_reference_level(ref_lvl), .fault(fault), .overcurrent(oc),
        .output_above(oa), .low_side_fallen(lsf), .high_gate_fallen(hgf));

    // Counts a failed comparison.
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer, held until ready is sampled high.
    task automatic apb_xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 16);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            mismatches++;
            $display("ERROR at %0t: bus timeout", $time);
            wrap_up();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb_xfer(a, 1'b1, d);
    endtask

    // Reads and compares the masked word.
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
        apb_xfer(a, 1'b0, 32'h00000000);
        check_word(rd_data & mask, exp);
    endtask

    // Waits for a reference level, returning the cycles spent.
    task automatic wait_ref(input logic [6:0] lvl);
        n = 0;
        while (ref_lvl !== lvl && n < 20000)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        if (n >= 20000)
        begin
            mismatches++;
            $display("ERROR at %0t: reference wait timeout", $time);
            wrap_up();
        end
    endtask

    // Counts rising edges of each gate over a window.
    task automatic count_edges(input int cycles);
        bps_gate_t last;
        hs = 0;
        lo = 0;
        bs = 0;
        last = gates;
        repeat (cycles)
        begin
            @(posedge pclk);
            #1;
            hs += int'(gates.high_side && !last.high_side);
            lo += int'(gates.low_side_gate_drive && !last.low_side_gate_drive);
            bs += int'(gates.bootstrap_refresh_switch && !last.bootstrap_refresh_switch);
            last = gates;
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Main sequence.
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {sync_on, rise, fall, fault} = '0;
        enable = 1'b1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_CTRL, 32'h0, 32'hffffffff);
        rd(ADDR_DUTY, {24'h0, DUTY_RESET}, 32'hffffffff);
        wr(ADDR_PERIOD, 32'h3);
        rd(ADDR_PERIOD, {16'h0, PERIOD_RESET}, 32'hffffffff);
        rd(8'h10, 32'h0, 32'hffffffff);
        check_word(rd_err, 1);
        wr(ADDR_PERIOD, 32'h4);
        $display("test registers done");
        repeat (20) @(posedge pclk);
        #1;
        check_word({gates, ref_lvl}, 0);
        rise <= 1'b1;
        fall <= 1'b1;
        $display("test lockout done");
        wait_ref(7'h01);
        wait_ref(7'h02);
        check_word(n, 256);
        wait_ref(7'h40);
        check_word(n, 62 * 256);
        check_word(flag_oe_n, 0);
        rd(ADDR_STATUS, 32'h3, 32'h3);
        $display("test soft start done");
        wr(ADDR_PERIOD, 32'h20);
        wr(ADDR_DUTY, 32'h40);
        repeat (100) @(posedge pclk);
        count_edges(512);
        check_word(hs, 16);
        check_word(lo, 0);
        check_word(bs, 4);
        wr(ADDR_CTRL, 32'h1);
        repeat (100) @(posedge pclk);
        count_edges(512);
        check_word(hs, 16);
        check_word(lo, 16);
        check_word(bs, 0);
        check_word(flag_oe_n, 1);
        $display("test switching done");
        sync_on <= 1'b1;
        repeat (100) @(posedge pclk);
        rd(ADDR_STATUS, 32'h00100000, 32'h00100000);
        sync_on <= 1'b0;
        repeat (90) @(posedge pclk);
        rd(ADDR_STATUS, 32'h0, 32'h00100000);
        fault <= 1'b1;
        repeat (80) @(posedge pclk);
        rd(ADDR_STATUS, 32'h00080000, 32'h00080000);
        fault <= 1'b0;
        repeat (300) @(posedge pclk);
        $display("test sync and fault done");
        wr(ADDR_PERIOD, 32'h4);
        enable <= 1'b0;
        repeat (8) @(posedge pclk);
        #1;
        check_word({gates, flag_oe_n}, 0);
        check_word(ref_lvl != 7'h00, 1);
        wait_ref(7'h00);
        check_word(n > 15000, 1);
        rd(ADDR_STATUS, 32'h0, 32'h3);
        $display("test soft stop done");
        wrap_up();
    end
endmodule
